// ===== dual_fifo_host_output.v
// dual event fifo with host register window, flush and interrupt decision
// assumes events arrive as single bytes tagged by sensor id, one per cycle,
// and host register accesses are single-cycle strobes synchronous to clk
`timescale 1ns/1ps
`include "hub_fifo_defines.vh"
module dual_fifo_host_output (
	input  wire       clk,            // 200 mhz clock
	input  wire       rst,            // async reset, active high
	input  wire       ev_valid,       // event byte strobe
	input  wire [7:0] ev_id,          // sensor id of event
	input  wire [7:0] ev_data,        // event byte
	input  wire       ev_zero_lat,    // sensor configured with zero latency
	input  wire       ev_meta,        // meta event (error, self-test, rate change...)
	input  wire       ev_timestamp,   // timestamp byte, goes to both fifos
	input  wire       lat_expired,    // a batching timeout expired, one pulse
	input  wire       lat_wake,       // expired sensor belongs to wake-up class
	input  wire [4:0] wake_wm,        // wake-up watermark in bytes, 0 off
	input  wire [4:0] nwake_wm,       // non-wake-up watermark in bytes, 0 off
	input  wire       wake_irq_dis,   // wake-up fifo interrupt disable
	input  wire       nwake_irq_dis,  // non-wake-up fifo interrupt disable
	input  wire       host_suspend,   // host processor suspended
	input  wire       update_count,   // host demand to refresh byte count, pulse
	input  wire       standby_done,   // standby request has taken effect
	input  wire       reset_request,  // reset requested through reset register
	input  wire       rd_en,          // host register read strobe
	input  wire       wr_en,          // host register write strobe
	input  wire [7:0] addr,           // host register address
	input  wire [7:0] wdata,          // host write data
	output reg  [7:0] rdata,          // host read data, registered
	output reg        host_irq,       // host interrupt pin, active high
	output reg        cpu_run,        // cpu run request
	output reg        upload_en       // ram patch upload enable
);
	// ****************************************************************
	// storage
	// ****************************************************************
	reg [7:0]           mem_q [0:1][0:`FIFO_DEPTH-1];
	reg [`FIFO_AW-1:0]  wp_q [0:1];
	reg [`FIFO_AW-1:0]  rp_q [0:1];
	reg [`FIFO_AW:0]    cnt_q [0:1];
	reg [15:0]          announce_q;  // announced byte count
	reg [`FIFO_AW:0]    take_q [0:1];// bytes of each fifo inside current burst
	reg [6:1]           cause_q;
	reg                 standby_q;
	reg                 rst_ind_q;
	reg                 resumed_q;
	reg                 pend_q;
	reg                 imm_w_q;     // wake immediate trigger, one cycle late
	reg                 imm_n_q;     // non-wake immediate trigger, one cycle late
	localparam [4:0]    DEPTH_CNT = `FIFO_DEPTH;

	wire ev_is_wake = ev_id > `WAKE_ID_LIMIT;
	// meta events always land in the non-wake-up fifo, timestamps in both
	reg  [1:0] push;
	always @* begin
		push = 2'b00;
		if (ev_valid) begin
			if (ev_timestamp) begin
				push = 2'b11;
			end else if (ev_meta || !ev_is_wake) begin
				push = 2'b01;
			end else begin
				push = 2'b10;
			end
		end
	end
	wire rd_win = rd_en && (addr <= `WINDOW_LAST_ADDR);
	// wake-up bytes leave first within one burst
	wire       src = (take_q[1] != 5'd0);
	wire       pop = rd_win && (announce_q != 16'h0000);
	wire       flush_wr = wr_en && (addr == `FLUSH_ADDR) && (wdata != `FLUSH_NONE);
	wire       flush_wk = (wdata == `FLUSH_ALL) || (wdata > `WAKE_ID_LIMIT);
	wire       flush_nw = (wdata == `FLUSH_ALL) || (wdata <= `WAKE_ID_LIMIT);
	wire wm_w = !wake_irq_dis && wake_wm != 5'd0 && cnt_q[1] >= wake_wm;
	wire wm_n = !nwake_irq_dis && nwake_wm != 5'd0 && cnt_q[0] >= nwake_wm;
	wire imm_w = push[1] && ev_zero_lat && !wake_irq_dis;
	wire imm_n = push[0] && ev_zero_lat && !nwake_irq_dis && !host_suspend;
	wire lat = lat_expired && !(lat_wake ? wake_irq_dis : nwake_irq_dis);
	wire resume = resumed_q && !host_suspend;
	// non-flush trigger: all of both fifos
	wire trig_all = wm_w || wm_n || imm_w_q || imm_n_q || lat || resume || pend_q;
	wire idle = (announce_q == 16'h0000);
	wire last = pop && (announce_q == 16'h0001);
	wire       start  = idle && (flush_wr || trig_all || update_count);
	wire [4:0] take_w = (!flush_wr || flush_wk) ? cnt_q[1] : 5'd0;
	wire [4:0] take_n = (!flush_wr || flush_nw) ? cnt_q[0] : 5'd0;
	wire       raise  = (flush_wr || trig_all) && (take_w != 5'd0 || take_n != 5'd0);

	// ****************************************************************
	// per fifo pointers and payload
	// ****************************************************************
	genvar f;
	generate
		for (f = 0; f < 2; f = f + 1) begin : g_fifo
			wire pf   = pop && (src == (f == 1));
			wire full = (cnt_q[f] == DEPTH_CNT);
			// suspended host lets the non-wake fifo drop its oldest byte
			wire drop = push[f] && full && (f == 0) && host_suspend
				&& (take_q[f] == 5'd0);
			wire wr = push[f] && (!full || drop);
			wire rd = pf || drop;
			always @(posedge clk) begin
				if (wr) begin
					mem_q[f][wp_q[f]] <= ev_data;
				end
			end
			always @(posedge clk or posedge rst) begin
				if (rst) begin
					wp_q[f]  <= 4'h0;
					rp_q[f]  <= 4'h0;
					cnt_q[f] <= 5'd0;
				end else begin
					if (wr) begin
						wp_q[f] <= wp_q[f] + 4'h1;
					end
					if (rd) begin
						rp_q[f] <= rp_q[f] + 4'h1;
					end
					cnt_q[f] <= cnt_q[f] + {4'h0, wr} - {4'h0, rd};
				end
			end
		end
	endgenerate

	// ****************************************************************
	// deferred immediate triggers
	// ****************************************************************
	// an immediate event only counts once it sits in its fifo, so its
	// trigger waits one cycle for the push to land
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			imm_w_q <= 1'b0;
			imm_n_q <= 1'b0;
		end else begin
			imm_w_q <= imm_w;
			imm_n_q <= imm_n;
		end
	end

	// ****************************************************************
	// suspend exit
	// ****************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			resumed_q <= 1'b0;
		end else if (host_suspend) begin
			resumed_q <= 1'b1;
		end else if (resume) begin
			resumed_q <= 1'b0;
		end
	end

	// ****************************************************************
	// burst announcement
	// ****************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			announce_q <= 16'h0000;
			take_q[0]  <= 5'd0;
			take_q[1]  <= 5'd0;
			pend_q     <= 1'b0;
		end else if (start) begin
			// count is latched on the same edge the pin rises
			take_q[1]  <= take_w;
			take_q[0]  <= take_n;
			announce_q <= {11'h000, take_w} + {11'h000, take_n};
			pend_q     <= 1'b0;
		end else begin
			if (!idle && trig_all) begin
				pend_q <= 1'b1;  // reasserts after this burst
			end
			if (pop) begin
				announce_q <= announce_q - 16'h0001;
				if (src) begin
					take_q[1] <= take_q[1] - 5'd1;
				end else begin
					take_q[0] <= take_q[0] - 5'd1;
				end
			end
		end
	end

	// ****************************************************************
	// host interrupt pin
	// ****************************************************************
	// the pin rises only when bytes were announced; an empty flush would
	// otherwise leave it high with nothing to read
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			host_irq <= 1'b0;
		end else if (start) begin
			host_irq <= raise;
		end else if (last) begin
			host_irq <= 1'b0;
		end
	end

	// ****************************************************************
	// interrupt causes
	// ****************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cause_q <= 6'h00;
		end else begin
			// causes stick until the burst is drained; set wins
			cause_q <= (last ? 6'h00 : cause_q) | {imm_n, lat && !lat_wake, wm_n,
				imm_w, lat && lat_wake, wm_w};
		end
	end

	// ****************************************************************
	// chip control
	// ****************************************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_run   <= 1'b0;
			upload_en <= 1'b0;
		end else if (wr_en && addr == `CHIP_CTRL_ADDR) begin
			cpu_run   <= wdata[`CPU_RUN_BIT];
			upload_en <= wdata[`UPLOAD_EN_BIT];
		end
	end

	// ****************************************************************
	// host status
	// ****************************************************************
	// reset indication is sticky: a reset or reset_request puts it up, nothing here
	// takes it down
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			standby_q <= 1'b0;
			rst_ind_q <= 1'b1;
		end else begin
			standby_q <= standby_done;
			if (reset_request) begin
				rst_ind_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// register read port
	// ****************************************************************
	// a window read past the announced count returns zero and leaves the
	// fifo where it is, so a host that over-reads loses nothing
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			if (rd_win) begin
				if (pop) begin
					rdata <= mem_q[src][rp_q[src]];
				end else begin
					rdata <= 8'h00;
				end
			end else begin
				case (addr)
				`FLUSH_ADDR: begin
					rdata <= 8'h00;
				end
				`CHIP_CTRL_ADDR: begin
					rdata <= {6'h00, upload_en, cpu_run};
				end
				`HOST_STATUS_ADDR: begin
					rdata <= {`FUSION_LIBRARY_CODE, `HOST_PROTOCOL_GENERATION,
						standby_q, rst_ind_q};
				end
				`INT_STATUS_ADDR: begin
					rdata <= {1'b0, cause_q, host_irq};
				end
				`COUNT_LO_ADDR: begin
					rdata <= announce_q[7:0];
				end
				`COUNT_HI_ADDR: begin
					rdata <= announce_q[15:8];
				end
				default: begin
					rdata <= 8'h00;
				end
				endcase
			end
		end
	end
endmodule // dual_fifo_host_output

// ===== hub_fifo_defines.vh
// register map, field positions and sizes of the host output path
// assumes inclusion by bare name from the output path module
`ifndef HUB_FIFO_DEFINES_VH
`define HUB_FIFO_DEFINES_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define WINDOW_LAST_ADDR   8'h31
`define FLUSH_ADDR         8'h32
`define CHIP_CTRL_ADDR     8'h34
`define HOST_STATUS_ADDR   8'h35
`define INT_STATUS_ADDR    8'h36
`define COUNT_LO_ADDR      8'h38
`define COUNT_HI_ADDR      8'h39
// ****************************************************************
// field values and sizes
// ****************************************************************
`define FLUSH_NONE         8'h00
`define FLUSH_ALL          8'hff
`define WAKE_ID_LIMIT      8'h20
`define CPU_RUN_BIT        0
`define UPLOAD_EN_BIT      1
`define FUSION_LIBRARY_CODE       3'h0
`define HOST_PROTOCOL_GENERATION  3'h1
`define FIFO_DEPTH         16
`define FIFO_AW            4
`define IST_HOST_IRQ       0
`define IST_WAKE_WM        1
`define IST_WAKE_LAT       2
`define IST_WAKE_IMM       3
`define IST_NWAKE_WM       4
`define IST_NWAKE_LAT      5
`define IST_NWAKE_IMM      6
`endif

// ===== fifo_out_checker.sv
// port assertions for the host output path
// assumes a bind onto the output path module
`timescale 1ns/1ps
module fifo_out_checker (
	input wire       clk,           // clock
	input wire       rst,           // reset
	input wire       ev_valid,      // event
	input wire       ev_zero_lat,   // no latency
	input wire       ev_timestamp,  // timestamp
	input wire       host_suspend,  // suspend
	input wire       wake_irq_dis,  // disable
	input wire       nwake_irq_dis, // disable
	input wire       standby_done,  // standby
	input wire       rd_en,         // read
	input wire       wr_en,         // write
	input wire [7:0] addr,          // address
	input wire [7:0] wdata,         // wdata
	input wire [7:0] rdata,         // rdata
	input wire       host_irq,      // irq pin
	input wire       cpu_run,       // run
	input wire       upload_en      // upload
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_irq_mirror: assert property (rd_en && addr == 8'h36 |=> rdata[0] == $past(host_irq))
		else $error("irq bit off");
	a_cause_reserved: assert property (rd_en && addr == 8'h36 |=> !rdata[7])
		else $error("bit7 set");
	a_ctrl_upper: assert property (rd_en && addr == 8'h34 |=> rdata[7:2] == 6'h00)
		else $error("ctrl upper");
	a_status_ids: assert property (rd_en && addr == 8'h35 |=> rdata[7:2] == 6'h01 && rdata[0])
		else $error("status ids");
	a_standby_seen: assert property (rd_en && addr == 8'h35 |=> rdata[1] == $past(standby_done, 2))
		else $error("standby bit");
	a_ctrl_write: assert property (wr_en && addr == 8'h34 |=> {upload_en, cpu_run} == $past(wdata[1:0]))
		else $error("ctrl write");
	a_irq_holds: assert property (host_irq && !rd_en |=> host_irq)
		else $error("irq dropped");
	a_zero_lat_irq: assert property (ev_valid && ev_zero_lat && !ev_timestamp && !host_suspend
		&& !wake_irq_dis && !nwake_irq_dis && !host_irq |-> ##[1:3] host_irq) else $error("no irq");
endmodule // fifo_out_checker

// ===== host_reader.sv
// host processor model: single-cycle register strobes
// assumes the output path samples strobes on the rising edge
`timescale 1ns/1ps
module host_reader (
	input  wire       clk,   // clock
	input  wire [7:0] rdata, // read data
	output reg        rd_en, // read strobe
	output reg        wr_en, // write strobe
	output reg  [7:0] addr,  // address
	output reg  [7:0] wdata  // write data
);
	initial {rd_en, wr_en, addr, wdata} = 18'h0;
	// released address and data lines show the inverse so a stale value never passes
	task acc(input we, input [7:0] a, input [7:0] v, output [7:0] d);
		begin
			@(negedge clk);
			{rd_en, wr_en, addr, wdata} = {!we, we, a, v};
			@(negedge clk);
			{rd_en, wr_en, addr, wdata} = {2'b00, ~a, ~v};
			d = rdata;
		end
	endtask
endmodule // host_reader

// ===== test_dual_fifo_host_output.sv
// bench: queue model of both fifos against the output path
// assumes host_reader and fifo_out_checker compiled first
`timescale 1ns/1ps
`include "hub_fifo_defines.vh"
module test_dual_fifo_host_output;
	reg        clk, rst, ev_valid, ev_zero_lat, ev_meta, ev_timestamp, lat_expired, lat_wake;
	reg        wake_irq_dis, nwake_irq_dis, host_suspend, update_count, standby_done, reset_request;
	reg  [7:0] ev_id, ev_data, d, lo, wq[$], nq[$], xq[$];
	reg  [4:0] wake_wm, nwake_wm;
	wire       rd_en, wr_en, host_irq, cpu_run, upload_en;
	wire [7:0] addr, wdata, rdata;
	integer    err_count = 0, check_count = 0, i, j, n;
	dual_fifo_host_output u_dut (.clk, .rst, .ev_valid, .ev_id, .ev_data, .ev_zero_lat, .ev_meta,
		.ev_timestamp, .lat_expired, .lat_wake, .wake_wm, .nwake_wm, .wake_irq_dis, .nwake_irq_dis,
		.host_suspend, .update_count, .standby_done, .reset_request, .rd_en, .wr_en, .addr, .wdata,
		.rdata, .host_irq, .cpu_run, .upload_en);
	host_reader u_host (.clk, .rdata, .rd_en, .wr_en, .addr, .wdata);
	task chk(input [15:0] seen, input [15:0] exp, input [63:0] what);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED %0s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	task summarize;
		begin
			if (err_count == 0 && check_count > 0) $display("All checks passed");
			else $display("Checks failed");
			$finish;
		end
	endtask
	task ev(input [7:0] id, input zl, input mt, input ts);
		begin
			@(negedge clk);
			{ev_valid, ev_id, ev_zero_lat, ev_meta, ev_timestamp} = {1'b1, id, zl, mt, ts};
			ev_data = 8'($urandom);
			if (ts || !mt && id > 8'h20) wq.push_back(ev_data);
			if ((ts || mt || id <= 8'h20) && nq.size() == `FIFO_DEPTH && host_suspend)
				void'(nq.pop_front());
			if (ts || mt || id <= 8'h20) nq.push_back(ev_data);
			@(negedge clk);
			ev_valid = 1'b0;
		end
	endtask
	task take;
		begin
			xq = {wq, nq};
			wq = {};
			nq = {};
		end
	endtask
	task drain(input [7:0] st);
		begin
			for (n = 0; n < 60 && host_irq !== 1'b1; n++) @(negedge clk);
			chk(n < 60, 1, "irq wait");
			if (n == 60) summarize;
			u_host.acc(0, 8'h36, 0, d);
			chk(d, st, "cause");
			u_host.acc(0, 8'h38, 0, lo);
			u_host.acc(0, 8'h39, 0, d);
			chk({d, lo}, 16'(xq.size()), "count");
			for (i = 0; i < xq.size(); i++) begin
				u_host.acc(0, 8'(i % 50), 0, d);
				chk(d, xq[i], "data");
			end
			u_host.acc(0, 8'h31, 0, d);
			chk(d, 0, "past end");
			u_host.acc(0, 8'h36, 0, d);
			chk(d, 0, "after");
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		{rst, ev_valid, ev_zero_lat, ev_meta, ev_timestamp, lat_expired, lat_wake} = 7'h40;
		{wake_irq_dis, nwake_irq_dis, host_suspend, update_count, standby_done, reset_request} = 0;
		{ev_id, ev_data, wake_wm, nwake_wm} = 0;
		void'($urandom(95));
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk({host_irq, cpu_run, upload_en, rdata}, 0, "reset");
		u_host.acc(0, 8'h35, 0, d);
		chk(d, 8'h05, "host st");
		standby_done = 1'b1;
		u_host.acc(0, 8'h35, 0, d);
		chk(d, 8'h07, "standby");
		lo = 8'($urandom);
		u_host.acc(1, 8'h34, lo, d);
		u_host.acc(0, 8'h34, 0, d);
		chk({cpu_run, upload_en, d}, {lo[0], lo[1], 6'h00, lo[1:0]}, "control");
		for (i = 0; i < 4; i++) ev(8'h21 + 8'(i), 0, i == 2, 0);
		for (i = 0; i < 4; i++) ev(i ? 8'h01 + 8'($urandom % 32) : 8'h20, 0, i[0], i == 3);
		lat_expired = 1'b1;
		@(negedge clk);
		lat_expired = 1'b0;
		take;
		drain(8'h21);
		for (j = 0; j < 2; j++) begin
			ev(j ? 8'h22 : 8'h05, 1, 0, 0);
			take;
			drain(j ? 8'h09 : 8'h41);
			{wake_wm, nwake_wm} = j ? 10'h040 : 10'h003;
			for (i = 0; i < 3 - j; i++) ev(j ? 8'h30 : 8'h10, 0, 0, 0);
			take;
			drain(j ? 8'h03 : 8'h11);
			{wake_wm, nwake_wm} = 0;
		end
		ev(8'h25, 0, 0, 0);
		ev(8'h09, 0, 0, 0);
		u_host.acc(1, 8'h32, 8'h00, d);
		repeat (8) @(negedge clk);
		chk(host_irq, 0, "nop");
		u_host.acc(1, 8'h32, 8'h25, d);
		xq = wq;
		wq = {};
		drain(8'h01);
		ev(8'h26, 0, 0, 0);
		u_host.acc(1, 8'h32, 8'hff, d);
		take;
		drain(8'h01);
		host_suspend = 1'b1;
		for (i = 0; i < 18; i++) ev(8'h02, 0, 0, 0);
		host_suspend = 1'b0;
		take;
		drain(8'h01);
		ev(8'h07, 0, 0, 0);
		update_count = 1'b1;
		@(negedge clk);
		update_count = 1'b0;
		take;
		u_host.acc(0, 8'h38, 0, d);
		chk({host_irq, d}, 16'h0001, "demand");
		u_host.acc(0, 8'h00, 0, d);
		chk(d, xq[0], "dem data");
		summarize;
	end
endmodule // test_dual_fifo_host_output
bind dual_fifo_host_output fifo_out_checker u_chk (.clk, .rst, .ev_valid, .ev_zero_lat,
	.ev_timestamp, .host_suspend, .wake_irq_dis, .nwake_irq_dis, .standby_done, .rd_en, .wr_en,
	.addr, .wdata, .rdata, .host_irq, .cpu_run, .upload_en);
